/* File: spi_link_tunnel_defs.vh */
`ifndef SPI_LINK_TUNNEL_DEFS_VH
`define SPI_LINK_TUNNEL_DEFS_VH

// Codes of the three-bit control channel mode field.
`define SPT_MODE_FWD        3'b110
`define SPT_MODE_REV        3'b111

// System clock period and back channel frame period, in ns.
`define SPT_CLK_NS          50
`define SPT_BC_FRAME_NS     7500

// Forward channel frame bit positions, one bit per sampled signal.
`define SPT_FWD_W           4
`define SPT_FWD_SCLK        0
`define SPT_FWD_MOSI        1
`define SPT_FWD_SS          2
`define SPT_FWD_MISO        3

// Back channel frame fields.
`define SPT_BC_W            9
`define SPT_BC_SS           0
`define SPT_BC_CNT_LO       1
`define SPT_BC_CNT_HI       3
`define SPT_BC_DAT_LO       4
`define SPT_BC_DAT_HI       7
`define SPT_BC_MISO         8

// Largest number of data samples one back channel frame may carry.
`define SPT_BC_BURST        3'h4

// Synchroniser lanes for the eight SPI pin inputs.
`define SPT_PIN_W           8
`define SPT_P_SER_SCLK      0
`define SPT_P_SER_MOSI      1
`define SPT_P_SER_SS        2
`define SPT_P_SER_MISO      3
`define SPT_P_DES_SCLK      4
`define SPT_P_DES_MOSI      5
`define SPT_P_DES_SS        6
`define SPT_P_DES_MISO      7

// Reverse regeneration states.
`define SPT_ST_IDLE         2'h0
`define SPT_ST_SETUP        2'h1
`define SPT_ST_HIGH         2'h2

`endif

/* File: spi_link_tunnel.v */
// Operation
// - Tunnel carries only SPI traffic; it never reaches configuration registers.
// - Mode field code 110 selects forward SPI, code 111 selects reverse SPI.
// - Serializer oversamples clock, MOSI and SS on pixel clock, no edge detection.
// - Each sample puts one bit per signal into the forward frame.
// - Far end rebuilds signals and freezes MOSI while regenerated clock is high.
// - Far end outputs regenerated clock one pixel clock after matching MOSI.
// - Reverse mode deserializer synchronises SS and clock into its own clock.
// - Reverse mode captures MOSI on active clock edge and buffers it.
// - Every back channel frame carries current SS with any buffered data.
// - Serializer regenerates reverse data from frames, possibly in bursts.
// - Reverse reads carry at most one sample per back channel frame.
// - Tunnel runs on the secondary lane, only in two-lane configuration.
`timescale 1ns/1ns
`include "spi_link_tunnel_defs.vh"

module spi_link_tunnel #(
    parameter BC_FRAME_CYCLES = (`SPT_BC_FRAME_NS + `SPT_CLK_NS - 1) / `SPT_CLK_NS,
    parameter BUF_DEPTH       = 8,
    parameter REV_HALF_CYCLES = 2
) (
    input  wire                   SYS_CLK_I,      // System and pixel clock.
    input  wire                   RSTN_I,         // Asynchronous reset, low active.
    input  wire [2:0]             MODE_I,         // Control channel mode field.
    input  wire                   CC_EN_I,        // Fast control channel enable.
    input  wire                   LOCK_I,         // Receiver lock.
    input  wire                   TWO_LANE_I,     // Link runs on two lanes.
    input  wire                   ONE_SAMPLE_I,   // Read transfer, one sample per frame.
    input  wire                   SER_SCLK_I,     // Serializer side master clock.
    input  wire                   SER_MOSI_I,     // Serializer side master data.
    input  wire                   SER_SS_N_I,     // Serializer side master select.
    output reg                    SER_MISO_O,     // Serializer side data to master.
    output reg                    SER_SCLK_O,     // Regenerated clock to local slave.
    output reg                    SER_MOSI_O,     // Regenerated data to local slave.
    output reg                    SER_SS_N_O,     // Regenerated select to local slave.
    input  wire                   SER_MISO_I,     // Local slave data.
    input  wire                   DES_SCLK_I,     // Deserializer side master clock.
    input  wire                   DES_MOSI_I,     // Deserializer side master data.
    input  wire                   DES_SS_N_I,     // Deserializer side master select.
    output reg                    DES_MISO_O,     // Deserializer side data to master.
    output reg                    DES_SCLK_O,     // Regenerated clock to far slave.
    output reg                    DES_MOSI_O,     // Regenerated data to far slave.
    output reg                    DES_SS_N_O,     // Regenerated select to far slave.
    input  wire                   DES_MISO_I,     // Far slave data.
    output reg  [`SPT_FWD_W-1:0]  FWD_FRAME_O,    // Forward frame, one per cycle.
    input  wire [`SPT_FWD_W-1:0]  FWD_FRAME_I,    // Forward frame from link.
    output reg  [`SPT_BC_W-1:0]   BC_FRAME_O,     // Back channel frame.
    output reg                    BC_VALID_O,     // Back channel frame strobe.
    input  wire [`SPT_BC_W-1:0]   BC_FRAME_I,     // Back channel frame from link.
    input  wire                   BC_VALID_I      // Back channel frame strobe from link.
);

    // Tunnel enables; the block has no register path at all, only SPI bits.
    wire chan_ok = CC_EN_I & LOCK_I & TWO_LANE_I;
    wire fwd_on  = chan_ok & (MODE_I == `SPT_MODE_FWD);
    wire rev_on  = chan_ok & (MODE_I == `SPT_MODE_REV);

    reg  [`SPT_PIN_W-1:0] pin_s1;
    reg  [`SPT_PIN_W-1:0] pin_s2;
    reg                   des_sclk_d;
    reg  [7:0]            bc_tmr;
    reg  [BUF_DEPTH-1:0]  cap_buf;
    reg  [3:0]            cap_cnt;
    reg  [BUF_DEPTH-1:0]  next_cap_buf;
    reg  [3:0]            next_cap_cnt;
    reg  [2:0]            pop_n;
    reg                   fwd_sclk_d;
    reg  [7:0]            pend;
    reg  [3:0]            pend_cnt;
    reg  [7:0]            next_pend;
    reg  [3:0]            next_pend_cnt;
    reg  [1:0]            st;
    reg  [7:0]            tmr;
    reg                   ss_rx;

    wire bc_tick  = (bc_tmr == 8'h00);
    wire des_edge = pin_s2[`SPT_P_DES_SCLK] & ~des_sclk_d;
    wire cap_push = rev_on & des_edge & ~pin_s2[`SPT_P_DES_SS];
    wire [2:0] lim = ONE_SAMPLE_I ? 3'h1 : `SPT_BC_BURST;
    wire [2:0] rx_n = BC_FRAME_I[`SPT_BC_CNT_HI:`SPT_BC_CNT_LO];
    wire [4:0] rx_mask = (5'h01 << rx_n) - 5'h01;
    wire [3:0] rx_bits = BC_FRAME_I[`SPT_BC_DAT_HI:`SPT_BC_DAT_LO] & rx_mask[3:0];
    wire rx_take = BC_VALID_I & rev_on;
    wire rg_pop  = rev_on & (st == `SPT_ST_IDLE) & (pend_cnt != 4'h0);

    // Two-stage synchronisers for every pin; nothing reads the first stage.
    always @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pin_s1 <= 8'h44;
            pin_s2 <= 8'h44;
        end else begin
            pin_s1 <= {DES_MISO_I, DES_SS_N_I, DES_MOSI_I, DES_SCLK_I,
                       SER_MISO_I, SER_SS_N_I, SER_MOSI_I, SER_SCLK_I};
            pin_s2 <= pin_s1;
        end
    end

    // Serializer forward sampler: raw oversampling of the three lines, each
    // cycle, so the far end sees every level change within one pixel clock.
    always @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            FWD_FRAME_O <= 4'h4;
        end else begin
            FWD_FRAME_O[`SPT_FWD_SCLK] <= fwd_on & pin_s2[`SPT_P_SER_SCLK];
            FWD_FRAME_O[`SPT_FWD_MOSI] <= fwd_on & pin_s2[`SPT_P_SER_MOSI];
            FWD_FRAME_O[`SPT_FWD_SS]   <= ~fwd_on | pin_s2[`SPT_P_SER_SS];
            FWD_FRAME_O[`SPT_FWD_MISO] <= rev_on & pin_s2[`SPT_P_SER_MISO];
        end
    end

    // Far end forward regeneration. The clock goes out one cycle behind its
    // data, and data is frozen while the rebuilt clock is high, so a slave
    // sampling on the rising edge always sees a settled bit.
    always @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            fwd_sclk_d <= 1'b0;
            DES_SCLK_O <= 1'b0;
            DES_MOSI_O <= 1'b0;
            DES_SS_N_O <= 1'b1;
            DES_MISO_O <= 1'b0;
        end else begin
            fwd_sclk_d <= fwd_on & FWD_FRAME_I[`SPT_FWD_SCLK];
            DES_SCLK_O <= fwd_on & fwd_sclk_d;
            if (!DES_SCLK_O) begin
                DES_MOSI_O <= fwd_on & FWD_FRAME_I[`SPT_FWD_MOSI];
            end
            DES_SS_N_O <= ~fwd_on | FWD_FRAME_I[`SPT_FWD_SS];
            DES_MISO_O <= rev_on & FWD_FRAME_I[`SPT_FWD_MISO];
        end
    end

    // Capture buffer: pop what the frame takes, then append the new bit.
    // A bit that arrives with the buffer full is dropped; the master must
    // pace itself to the back channel rate.
    always @* begin
        next_cap_buf = cap_buf;
        next_cap_cnt = cap_cnt;
        pop_n = (cap_cnt > {1'b0, lim}) ? lim : cap_cnt[2:0];
        if (bc_tick) begin
            next_cap_buf = cap_buf >> pop_n;
            next_cap_cnt = cap_cnt - {1'b0, pop_n};
        end
        if (cap_push && (next_cap_cnt < BUF_DEPTH)) begin
            next_cap_buf[next_cap_cnt[2:0]] = pin_s2[`SPT_P_DES_MOSI];
            next_cap_cnt = next_cap_cnt + 4'h1;
        end
    end

    // Reverse capture and back channel framing on the frame divider.
    always @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            des_sclk_d <= 1'b0;
            bc_tmr     <= 8'h00;
            cap_buf    <= {BUF_DEPTH{1'b0}};
            cap_cnt    <= 4'h0;
            BC_FRAME_O <= 9'h001;
            BC_VALID_O <= 1'b0;
        end else begin
            des_sclk_d <= pin_s2[`SPT_P_DES_SCLK];
            bc_tmr     <= bc_tick ? BC_FRAME_CYCLES[7:0] - 8'h01 : bc_tmr - 8'h01;
            cap_buf    <= rev_on ? next_cap_buf : {BUF_DEPTH{1'b0}};
            cap_cnt    <= rev_on ? next_cap_cnt : 4'h0;
            BC_VALID_O <= bc_tick;
            if (bc_tick) begin
                BC_FRAME_O[`SPT_BC_SS] <= ~rev_on | pin_s2[`SPT_P_DES_SS];
                BC_FRAME_O[`SPT_BC_CNT_HI:`SPT_BC_CNT_LO] <= rev_on ? pop_n : 3'h0;
                BC_FRAME_O[`SPT_BC_DAT_HI:`SPT_BC_DAT_LO] <= rev_on ? cap_buf[3:0] : 4'h0;
                BC_FRAME_O[`SPT_BC_MISO] <= fwd_on & pin_s2[`SPT_P_DES_MISO];
            end
        end
    end

    // Serializer pending bits: drain one per regenerated clock, append a
    // frame's worth at once, which is what makes the output bursty.
    always @* begin
        next_pend     = pend;
        next_pend_cnt = pend_cnt;
        if (rg_pop) begin
            next_pend     = pend >> 1;
            next_pend_cnt = pend_cnt - 4'h1;
        end
        if (rx_take) begin
            next_pend     = next_pend | ({4'h0, rx_bits} << next_pend_cnt);
            next_pend_cnt = next_pend_cnt + {1'b0, rx_n};
        end
    end

    // Reverse regeneration: data set up half a period before each rising
    // clock edge; select is released only after the queue has drained.
    always @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pend       <= 8'h00;
            pend_cnt   <= 4'h0;
            st         <= `SPT_ST_IDLE;
            tmr        <= 8'h00;
            ss_rx      <= 1'b1;
            SER_SCLK_O <= 1'b0;
            SER_MOSI_O <= 1'b0;
            SER_SS_N_O <= 1'b1;
            SER_MISO_O <= 1'b0;
        end else begin
            pend     <= rev_on ? next_pend : 8'h00;
            pend_cnt <= rev_on ? next_pend_cnt : 4'h0;
            if (rx_take) begin
                ss_rx <= BC_FRAME_I[`SPT_BC_SS];
            end else if (!rev_on) begin
                ss_rx <= 1'b1;
            end
            if (!fwd_on) begin
                SER_MISO_O <= 1'b0;
            end else if (BC_VALID_I) begin
                SER_MISO_O <= BC_FRAME_I[`SPT_BC_MISO];
            end
            if (!ss_rx) begin
                SER_SS_N_O <= 1'b0;
            end else if (pend_cnt == 4'h0 && st == `SPT_ST_IDLE) begin
                SER_SS_N_O <= 1'b1;
            end
            case (st)
                `SPT_ST_IDLE: begin
                    SER_SCLK_O <= 1'b0;
                    if (rg_pop) begin
                        SER_MOSI_O <= pend[0];
                        tmr        <= REV_HALF_CYCLES[7:0] - 8'h01;
                        st         <= `SPT_ST_SETUP;
                    end
                end
                `SPT_ST_SETUP: begin
                    if (tmr == 8'h00) begin
                        SER_SCLK_O <= 1'b1;
                        tmr        <= REV_HALF_CYCLES[7:0] - 8'h01;
                        st         <= `SPT_ST_HIGH;
                    end else begin
                        tmr <= tmr - 8'h01;
                    end
                end
                `SPT_ST_HIGH: begin
                    if (tmr == 8'h00) begin
                        SER_SCLK_O <= 1'b0;
                        st         <= `SPT_ST_IDLE;
                    end else begin
                        tmr <= tmr - 8'h01;
                    end
                end
                default: begin
                    SER_SCLK_O <= 1'b0;
                    st         <= `SPT_ST_IDLE;
                end
            endcase
        end
    end

endmodule

/* File: spi_link_tunnel_asserts.sv */
`timescale 1ns/1ns
`include "spi_link_tunnel_defs.vh"
module spi_link_tunnel_asserts #(
    parameter BC_FRAME_CYCLES = 150
) (
    input wire       SYS_CLK_I, RSTN_I, CC_EN_I, LOCK_I, TWO_LANE_I, ONE_SAMPLE_I, // Controls.
    input wire [2:0] MODE_I,                                                // Mode field.
    input wire       SER_SCLK_I, SER_MOSI_I, SER_SS_N_I, DES_SS_N_I, BC_VALID_I, // Pins in.
    input wire       SER_MISO_I, DES_MISO_I, DES_MISO_O,                     // Slave data.
    input wire       SER_MISO_O, SER_SCLK_O, SER_MOSI_O, DES_SCLK_O, DES_MOSI_O, // Pins out.
    input wire       DES_SS_N_O, BC_VALID_O,                                 // Select, strobe.
    input wire [3:0] FWD_FRAME_O, FWD_FRAME_I,                               // Forward frames.
    input wire [8:0] BC_FRAME_O, BC_FRAME_I                                  // Back frames.
);
    wire       ok = CC_EN_I & LOCK_I & TWO_LANE_I;
    reg [15:0] gap;
    reg        seen;

    // Cycles since the last strobe; the first strobe after reset has nothing to compare with.
    always @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            gap  <= 16'h0;
            seen <= 1'b0;
        end else begin
            gap  <= BC_VALID_O ? 16'h1 : gap + 16'h1;
            seen <= seen | BC_VALID_O;
        end
    end

    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RSTN_I);
    sequence fwd_on; (ok && MODE_I == `SPT_MODE_FWD)[*4]; endsequence
    sequence fwd_off; (!(ok && MODE_I == `SPT_MODE_FWD))[*2]; endsequence
    sequence rev_on; (ok && MODE_I == `SPT_MODE_REV)[*4]; endsequence
    sequence rev_ss; (ok && MODE_I == `SPT_MODE_REV && $stable(DES_SS_N_I))[*7]; endsequence
    sequence clk_pulse; SER_SCLK_O[*2] ##1 !SER_SCLK_O; endsequence

    AST_FWD_SAMPLE:
        assert property (fwd_on |-> FWD_FRAME_O[2:0] ==
            {$past(SER_SS_N_I, 3), $past(SER_MOSI_I, 3), $past(SER_SCLK_I, 3)})
        else $error("forward frame misses pin samples");
    AST_FWD_SCLK_LAG:
        assert property (fwd_on |-> DES_SCLK_O == $past(FWD_FRAME_I[`SPT_FWD_SCLK], 2))
        else $error("regenerated clock lag wrong");
    AST_FWD_MOSI:
        assert property (fwd_on |-> DES_MOSI_O == ($past(DES_SCLK_O) ? $past(DES_MOSI_O)
            : $past(FWD_FRAME_I[`SPT_FWD_MOSI]))) else $error("regenerated data wrong");
    AST_FWD_IDLE:
        assert property (fwd_off |-> !DES_SCLK_O && DES_SS_N_O) else $error("idle pins move");
    AST_BC_SS:
        assert property (rev_ss ##0 BC_VALID_O |-> BC_FRAME_O[`SPT_BC_SS] == DES_SS_N_I)
        else $error("frame select bit wrong");
    AST_BC_PERIOD:
        assert property (BC_VALID_O && seen |-> gap == BC_FRAME_CYCLES)
        else $error("frame period wrong");
    AST_BC_ONE:
        assert property (ONE_SAMPLE_I[*3] ##0 BC_VALID_O |-> BC_FRAME_O[3:1] <= 3'h1)
        else $error("read frame carries several samples");
    AST_FWD_MISO:
        assert property (fwd_on |-> SER_MISO_O == ($past(BC_VALID_I) ? $past(BC_FRAME_I[8])
            : $past(SER_MISO_O))) else $error("returned data wrong");
    AST_BC_MISO:
        assert property (fwd_on ##0 BC_VALID_O |-> BC_FRAME_O[8] == $past(DES_MISO_I, 3))
        else $error("back frame misses slave data");
    AST_REV_MISO_FRAME:
        assert property (rev_on |-> FWD_FRAME_O[3] == $past(SER_MISO_I, 3))
        else $error("forward frame misses slave data");
    AST_REV_MISO:
        assert property (rev_on |-> DES_MISO_O == $past(FWD_FRAME_I[3]))
        else $error("rebuilt slave data wrong");
    AST_REV_CLOCK:
        assert property ($rose(SER_SCLK_O) |-> clk_pulse and $stable(SER_MOSI_O)[*3])
        else $error("rebuilt clock pulse wrong");
endmodule

bind spi_link_tunnel spi_link_tunnel_asserts #(.BC_FRAME_CYCLES(BC_FRAME_CYCLES)) u_chk (.*);

/* File: spi_link_partner.sv */
`timescale 1ns/1ns
module spi_link_partner (
    input  wire       clk_i,    // System clock.
    input  wire       rstn_i,   // Reset, low active.
    input  wire       slow_i,   // One more cycle on the back channel.
    input  wire [3:0] fwd_tx_i, // Forward frame from the block.
    output wire [3:0] fwd_rx_o, // Forward frame at the far end.
    input  wire [9:0] bc_tx_i,  // Strobe and back frame from the block.
    output wire [9:0] bc_rx_o,  // Strobe and back frame at the far end.
    input  wire [1:0] sclk_i,   // Clocks at the two slaves.
    input  wire [1:0] ss_n_i,   // Selects at the two slaves.
    output reg  [1:0] miso_o    // Data of the two slaves.
);
    reg [9:0] d1, d2;
    reg [1:0] last;

    // The forward link is ideal; the back channel lags one or two cycles.
    assign fwd_rx_o = fwd_tx_i;
    assign bc_rx_o  = slow_i ? d2 : d1;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            d1 <= 10'h0;
            d2 <= 10'h0;
        end else begin
            d1 <= bc_tx_i;
            d2 <= d1;
        end
    end

    // Slaves shift on a falling clock; unselected, the line churns so no stale bit survives.
    // Reset clears both, since an unknown last or miso_o value would poison the churn for good.
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            last   <= 2'h0;
            miso_o <= 2'h0;
        end else begin
            last   <= sclk_i;
            miso_o <= miso_o ^ (ss_n_i | (last & ~sclk_i));
        end
    end
endmodule

/* File: test_spi_link_tunnel.sv */
`timescale 1ns/1ns
module test_spi_link_tunnel;
    localparam FRAME = 10;
    reg        SYS_CLK_I = 0, RSTN_I = 0, CC_EN_I = 0, LOCK_I = 0, TWO_LANE_I = 0;
    reg        ONE_SAMPLE_I = 0, SER_SCLK_I = 0, SER_MOSI_I = 0, SER_SS_N_I = 1, slow = 0;
    reg        DES_SCLK_I = 0, DES_MOSI_I = 0, DES_SS_N_I = 1, prev_des = 0, prev_ser = 0;
    reg  [2:0] MODE_I = 3'h0;
    wire       SER_MISO_O, SER_SCLK_O, SER_MOSI_O, SER_SS_N_O, SER_MISO_I, DES_MISO_O;
    wire       DES_SCLK_O, DES_MOSI_O, DES_SS_N_O, DES_MISO_I, BC_VALID_O, BC_VALID_I;
    wire [3:0] FWD_FRAME_O, FWD_FRAME_I;
    wire [8:0] BC_FRAME_O, BC_FRAME_I;
    integer    errors = 0, n_tests = 0, cycles = 0, i;
    reg [31:0] seed = 32'h6e23f005;
    reg        fwd_ok, rev_ok;
    logic      q_fwd[$], q_rev[$];

    spi_link_tunnel #(.BC_FRAME_CYCLES(FRAME)) DUT (
        .SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .MODE_I(MODE_I), .CC_EN_I(CC_EN_I),
        .LOCK_I(LOCK_I), .TWO_LANE_I(TWO_LANE_I), .ONE_SAMPLE_I(ONE_SAMPLE_I),
        .SER_SCLK_I(SER_SCLK_I), .SER_MOSI_I(SER_MOSI_I), .SER_SS_N_I(SER_SS_N_I),
        .SER_MISO_O(SER_MISO_O), .SER_SCLK_O(SER_SCLK_O), .SER_MOSI_O(SER_MOSI_O),
        .SER_SS_N_O(SER_SS_N_O), .SER_MISO_I(SER_MISO_I), .DES_SCLK_I(DES_SCLK_I),
        .DES_MOSI_I(DES_MOSI_I), .DES_SS_N_I(DES_SS_N_I), .DES_MISO_O(DES_MISO_O),
        .DES_SCLK_O(DES_SCLK_O), .DES_MOSI_O(DES_MOSI_O), .DES_SS_N_O(DES_SS_N_O),
        .DES_MISO_I(DES_MISO_I), .FWD_FRAME_O(FWD_FRAME_O), .FWD_FRAME_I(FWD_FRAME_I),
        .BC_FRAME_O(BC_FRAME_O), .BC_VALID_O(BC_VALID_O), .BC_FRAME_I(BC_FRAME_I),
        .BC_VALID_I(BC_VALID_I));
    spi_link_partner u_link (.clk_i(SYS_CLK_I), .rstn_i(RSTN_I), .slow_i(slow),
        .fwd_tx_i(FWD_FRAME_O), .fwd_rx_o(FWD_FRAME_I), .bc_tx_i({BC_VALID_O, BC_FRAME_O}),
        .bc_rx_o({BC_VALID_I, BC_FRAME_I}), .sclk_i({DES_SCLK_O, SER_SCLK_O}),
        .ss_n_i({DES_SS_N_O, SER_SS_N_O}), .miso_o({DES_MISO_I, SER_MISO_I}));

    always #25 SYS_CLK_I = ~SYS_CLK_I;

    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task check(input seen, input exp, input [8*10:1] what);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] %0s expected %b seen %b", what, exp, seen);
        end
    endtask

    task print_verdict;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Master pins of one side; side 1 is the deserializer end.
    task pins(input side, input ss_n, input sclk, input mosi);
        if (side) {DES_SS_N_I, DES_SCLK_I, DES_MOSI_I} = {ss_n, sclk, mosi};
        else {SER_SS_N_I, SER_SCLK_I, SER_MOSI_I} = {ss_n, sclk, mosi};
        repeat (4) @(negedge SYS_CLK_I);
    endtask

    // One byte, first bit first, clock idle low, 400 ns period; expected bits are noted.
    // A read waits a round trip before each sampling edge, which also keeps the queue short.
    task xfer(input side, input [7:0] d, input push, input rd);
        integer k;
        pins(side, 1'b0, 1'b0, 1'b0);
        for (k = 7; k >= 0; k = k - 1) begin
            if (push && side) q_rev.push_back(d[k]);
            if (push && !side) q_fwd.push_back(d[k]);
            pins(side, 1'b0, 1'b0, d[k]);
            if (rd) repeat (3 * FRAME) @(negedge SYS_CLK_I);
            pins(side, 1'b0, 1'b1, d[k]);
        end
        pins(side, 1'b0, 1'b0, d[0]);
        pins(side, 1'b1, 1'b0, 1'b0);
    endtask

    // A rebuilt clock rise takes the oldest noted bit; a rise with nothing noted is wrong.
    always @(negedge SYS_CLK_I) begin
        if (DES_SCLK_O === 1'b1 && !prev_des) begin
            check(DES_MOSI_O, q_fwd.size() ? q_fwd.pop_front() : ~DES_MOSI_O, "fwd_mosi");
            check(DES_SS_N_O, 1'b0, "fwd_ss");
        end
        if (SER_SCLK_O === 1'b1 && !prev_ser) begin
            check(SER_MOSI_O, q_rev.size() ? q_rev.pop_front() : ~SER_MOSI_O, "rev_mosi");
            check(SER_SS_N_O, 1'b0, "rev_ss");
        end
        prev_des = DES_SCLK_O === 1'b1;
        prev_ser = SER_SCLK_O === 1'b1;
    end

    // A hang counts as a mismatch; the run needs about 5800 cycles.
    always @(posedge SYS_CLK_I) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            print_verdict;
        end
    end

    // Every mode code, then each enable dropped in turn, with random bytes both ways.
    initial begin
        repeat (4) @(negedge SYS_CLK_I);
        RSTN_I = 1'b1;
        for (i = 0; i < 14; i = i + 1) begin
            seed = lfsr(seed);
            MODE_I = (i < 8) ? i[2:0] : {2'b11, i[0]};
            {CC_EN_I, LOCK_I, TWO_LANE_I} = (i < 8 || i > 10) ? 3'h7 : ~(3'h1 << (i - 8));
            ONE_SAMPLE_I = (i == 13) | (seed[0] & (i != 7));
            fwd_ok = CC_EN_I & LOCK_I & TWO_LANE_I & (MODE_I == 3'h6);
            rev_ok = CC_EN_I & LOCK_I & TWO_LANE_I & (MODE_I == 3'h7);
            @(posedge BC_VALID_O);
            repeat (4) @(negedge SYS_CLK_I);
            slow = seed[1];
            xfer(1'b0, seed[15:8], fwd_ok, 1'b0);
            xfer(1'b1, seed[23:16], rev_ok, ONE_SAMPLE_I);
            repeat (100) @(negedge SYS_CLK_I);
            check(q_fwd.size() == 0 && q_rev.size() == 0, 1'b1, "drained");
            check(SER_SS_N_O & DES_SS_N_O, 1'b1, "ss_idle");
        end
        print_verdict;
    end
endmodule
